// ---- vec_ops_consts.svh ----
// constants for the vector element float datapath
`ifndef VEC_OPS_CONSTS_SVH
`define VEC_OPS_CONSTS_SVH
`define OP_CEIL 8'h92
`define OP_SQRT 8'h93
`define OP_ASIG 8'h94
`define OP_AEXP 8'h95
`define OP_CTR 8'h96
`define OP_RCTR 8'h97
`define OP_XMIT 8'h98
`define OP_ABS 8'h99
`define OP_EXPX 8'h9a
`define OP_PACK 8'h9b
`define OP_EXT 8'h9c
`define OP_LOGIC 8'h9d
`define IND_TAG 4'h7
`define MZ_TAG 4'h8
`define IND64 64'h7000_0000_0000_0000
`define MZ64 64'h8000_0000_0000_0000
`define IND32 64'h0000_0000_7000_0000
`define MZ32 64'h0000_0000_8000_0000
`define EXP_MAX 18'sh06fff
`define EXP_MIN 18'sh39000
`define EXP_MAX32 18'sh0006f
`define EXP_MIN32 18'sh3ff90
`define CTR_BIAS 18'sd24
`define RCTR_BIAS 18'sd25
`define ROUND_ONE 49'h0_0000_0080_0000
`define COEF_MNEG 48'h8000_0000_0000
`define SQRT_EVEN 18'sd46
`define SQRT_ODD 18'sd47
`define SH_CAP 6'd63
`define SH_CAP_W 18'sd63
`define F41 0
`define F42 1
`define F43 2
`define F45 4
`define F46 5
`define SUB_W32 7
`define SUB_BCA 4
`define SUB_FN 2:0
`define REG_CTRL 12'h000
`define REG_STAT 12'h004
`define CTRL_OP 7:0
`define CTRL_SUB 15:8
`define CTRL_RST 16'h0000
`define STAT_CNT 31:16
`define STAT_FLG 5:0
`define STAT_PAD 10'h000
`endif

// ---- vec_ops_pkg.sv ----
// types for the vector element float datapath
package vec_ops_pkg;
   typedef logic [63:0] elem_t;
   typedef logic [5:0] flags_t;
   typedef logic signed [17:0] wexp_t;
endpackage

// ---- vector_element_float_ops.sv ----
// element-wise vector float datapath with apb control
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "vec_ops_consts.svh"
module vector_element_float_ops
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [63:0] a_elem,
   input wire logic [63:0] b_elem,
   output logic out_valid,
   input wire logic out_ready,
   output logic [63:0] c_elem,
   output logic [5:0] c_flags,
   output logic a_reg_is_32
);
   logic [15:0] ctrl;
   logic [5:0] stat_flg;
   logic [15:0] stat_cnt;
   logic setup_seen;
   wire [7:0] op = ctrl[`CTRL_OP];
   wire [7:0] sub = ctrl[`CTRL_SUB];
   wire w32 = sub[`SUB_W32];
   wire load = in_valid & in_ready;

   // operand fields
   wire signed [15:0] a_e = a_elem[63:48];
   wire signed [15:0] b_e = b_elem[63:48];
   wire signed [47:0] a_c = a_elem[47:0];
   wire vec_ops_pkg::wexp_t a_ex = {{2{a_e[15]}}, a_e};
   wire vec_ops_pkg::wexp_t b_ex = {{2{b_e[15]}}, b_e};
   wire a_ind = a_e[15:12] == `IND_TAG;
   wire a_mz = a_e[15:12] == `MZ_TAG;
   wire b_ind = b_e[15:12] == `IND_TAG;
   wire b_mz = b_e[15:12] == `MZ_TAG;
   wire a_end = a_ind | a_mz;
   wire signed [7:0] x_e = a_elem[31:24];
   wire x_ind = x_e[7:4] == `IND_TAG;
   wire x_mz = x_e[7:4] == `MZ_TAG;

   function automatic logic [5:0] norm_dist(input logic [47:0] c);
      logic [5:0] n;
      logic done;
      n = 6'd0;
      done = 1'b0;
      for (int i = 46; i >= 0; i--)
      begin
         if (!done && c[i] == c[47])
            n = n + 6'd1;
         else
            done = 1'b1;
      end
      return n;
   endfunction

   // bitwise search; slow but small and exact
   function automatic logic [47:0] isqrt(input logic [94:0] v);
      logic [47:0] q;
      logic [47:0] t;
      logic [95:0] sq;
      q = 48'h0;
      for (int i = 47; i >= 0; i--)
      begin
         t = q | (48'h1 << i);
         sq = t * t;
         if (sq <= {1'b0, v})
            q = t;
      end
      return q;
   endfunction

   wire [5:0] nd = norm_dist(a_c);

   // ceiling
   wire vec_ops_pkg::wexp_t neg_e = 18'sd0 - a_ex;
   wire [5:0] ceil_n = (neg_e > `SH_CAP_W) ? `SH_CAP : neg_e[5:0];
   wire signed [47:0] ceil_t = -a_c;
   wire signed [47:0] ceil_s = ceil_t >>> ceil_n;
   wire signed [47:0] ceil_c = -ceil_s;

   // adjust significance
   wire signed [47:0] cnt = w32 ?
      {{24{b_elem[23]}}, b_elem[23:0]} : b_elem[47:0];
   wire cnt_neg = cnt[47];
   wire [47:0] cmag = cnt_neg ? 48'h0 - cnt : cnt;
   // counts past 47 are undefined; capping keeps it cheap
   wire [5:0] sh6 = (cmag[47:6] != 42'h0) ? `SH_CAP : cmag[5:0];
   wire [5:0] lsh = (a_c == 48'h0 || sh6 < nd) ? sh6 : nd;
   wire signed [47:0] as_c = cnt_neg ? (a_c >>> sh6) : (a_c << lsh);
   wire vec_ops_pkg::wexp_t as_e = cnt_neg ?
      a_ex + $signed({12'h0, sh6}) : a_ex - $signed({12'h0, lsh});

   // adjust exponent
   wire vec_ops_pkg::wexp_t d = a_ex - b_ex;
   wire vec_ops_pkg::wexp_t neg_d = 18'sd0 - d;
   wire d_pos = !d[17] && d != 18'sd0;
   wire ae_big = d > $signed({12'h0, nd});
   wire [5:0] d_r = (neg_d > `SH_CAP_W) ? `SH_CAP : neg_d[5:0];
   wire signed [47:0] ae_c = d_pos ? (a_c << d[5:0]) : (a_c >>> d_r);
   wire ae_endc = a_end | b_ind | b_mz;

   // rounded contract
   wire [48:0] rsum = {a_c[47], a_c} + `ROUND_ONE;
   wire rovf = rsum[48] != rsum[47];

   // square root
   wire sq_odd = a_e[0];
   wire [94:0] rad = sq_odd ? {a_c, 47'h0} : {1'b0, a_c, 46'h0};
   wire [47:0] root = isqrt(rad);
   wire vec_ops_pkg::wexp_t sq_e0 = a_ex -
      (sq_odd ? `SQRT_ODD : `SQRT_EVEN);
   wire vec_ops_pkg::wexp_t sq_e = sq_e0 >>> 1;

   // logical
   logic [63:0] lg;
   always_comb
   begin
      unique case (sub[`SUB_FN])
         3'h0: lg = a_elem ^ b_elem;
         3'h1: lg = a_elem | b_elem;
         3'h2: lg = a_elem & b_elem;
         3'h3: lg = ~(a_elem & b_elem);
         3'h4: lg = ~(a_elem | b_elem);
         3'h5: lg = ~a_elem | b_elem;
         3'h6: lg = a_elem & ~b_elem;
         3'h7: lg = ~(a_elem ^ b_elem);
      endcase
   end

   vec_ops_pkg::elem_t res;
   vec_ops_pkg::flags_t fl;
   vec_ops_pkg::wexp_t r_e;
   logic [47:0] r_c;
   logic chk;
   logic chk32;

   always_comb
   begin
      res = 64'h0;
      fl = 6'h0;
      r_e = 18'sd0;
      r_c = 48'h0;
      chk = 1'b0;
      chk32 = 1'b0;
      case (op)
         `OP_CEIL:
            if (a_mz)
               res = 64'h0;
            else if (a_ind)
            begin
               res = `IND64;
               fl[`F46] = 1'b1;
            end
            else if (!a_e[15])
               res = a_elem;
            else
               res = {16'h0, ceil_c};
         `OP_SQRT:
            if (a_mz)
            begin
               res = `MZ64;
               fl[`F43] = 1'b1;
            end
            else if (a_ind)
            begin
               res = `IND64;
               fl[`F46] = 1'b1;
            end
            else if (a_c[47])
            begin
               res = `IND64;
               fl[`F45] = 1'b1;
            end
            else
            begin
               r_e = sq_e;
               r_c = root;
               chk = 1'b1;
            end
         `OP_ASIG:
            if (a_ind)
            begin
               res = `IND64;
               fl[`F46] = 1'b1;
            end
            else if (a_mz)
            begin
               res = `MZ64;
               fl[`F43] = 1'b1;
            end
            else
            begin
               r_e = as_e;
               r_c = as_c;
               chk = 1'b1;
            end
         `OP_AEXP:
            if (ae_endc)
            begin
               res = `IND64;
               fl[`F46] = 1'b1;
            end
            else if (a_c == 48'h0)
               res = {b_e, 48'h0};
            else if (d_pos && ae_big)
            begin
               res = `IND64;
               fl[`F42] = 1'b1;
            end
            else
               res = {b_e, ae_c};
         `OP_CTR, `OP_RCTR:
            if (a_ind)
            begin
               res = `IND32;
               fl[`F46] = 1'b1;
            end
            else if (a_mz)
            begin
               res = `MZ32;
               fl[`F43] = 1'b1;
            end
            else if (op == `OP_CTR)
            begin
               r_e = a_ex + `CTR_BIAS;
               r_c = {24'h0, a_c[47:24]};
               chk32 = 1'b1;
            end
            else
            begin
               r_e = a_ex + (rovf ? `RCTR_BIAS : `CTR_BIAS);
               r_c = {24'h0, rovf ? rsum[48:25] : rsum[47:24]};
               chk32 = 1'b1;
            end
         `OP_XMIT:
            res = a_elem;
         `OP_ABS:
            if (a_ind)
            begin
               res = `IND64;
               fl[`F46] = 1'b1;
            end
            else if (a_mz)
            begin
               res = a_elem;
               fl[`F43] = 1'b1;
            end
            else if (a_c == `COEF_MNEG)
            begin
               // magnitude does not fit the coefficient
               res = `IND64;
               fl[`F42] = 1'b1;
            end
            else
               res = {a_e, a_c[47] ? -a_c : a_c};
         `OP_EXPX:
            res = {16'h0, {32{a_e[15]}}, a_e};
         `OP_PACK:
            res = w32 ? {32'h0, a_elem[7:0], b_elem[23:0]}
               : {a_elem[15:0], b_elem[47:0]};
         `OP_EXT:
            if (x_ind)
            begin
               res = `IND64;
               fl[`F46] = 1'b1;
            end
            else if (x_mz)
            begin
               res = `MZ64;
               fl[`F43] = 1'b1;
            end
            else
            begin
               r_e = {{10{x_e[7]}}, x_e} - `CTR_BIAS;
               r_c = {a_elem[23:0], 24'h0};
               chk = 1'b1;
            end
         `OP_LOGIC:
            res = lg;
         default:
            res = 64'h0;
      endcase
      // exponent range after adjustment
      if (chk)
      begin
         if (r_e > `EXP_MAX)
         begin
            res = `IND64;
            fl[`F42] = 1'b1;
         end
         else if (r_e < `EXP_MIN)
         begin
            res = `MZ64;
            fl[`F43] = 1'b1;
         end
         else
            res = {r_e[15:0], r_c};
      end
      if (chk32)
      begin
         if (r_e > `EXP_MAX32)
         begin
            res = `IND32;
            fl[`F42] = 1'b1;
         end
         else if (r_e < `EXP_MIN32)
         begin
            res = `MZ32;
            fl[`F43] = 1'b1;
         end
         else
            res = {32'h0, r_e[7:0], r_c[23:0]};
      end
   end

   assign in_ready = ce & (~out_valid | out_ready);
   assign a_reg_is_32 = (op == `OP_EXT) & sub[`SUB_BCA];

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         out_valid <= 1'b0;
         c_elem <= 64'h0;
         c_flags <= 6'h0;
      end
      else if (ce)
      begin
         if (load)
         begin
            out_valid <= 1'b1;
            c_elem <= res;
            c_flags <= fl;
         end
         else if (out_ready)
            out_valid <= 1'b0;
      end
   end

   // apb slave: read data latched in setup, one wait-free access
   wire sel_ctrl = paddr == `REG_CTRL;
   wire sel_stat = paddr == `REG_STAT;
   wire hit = sel_ctrl | sel_stat;
   wire acc = psel & penable & pready;
   wire wr_ctrl = acc & pwrite & sel_ctrl;
   wire wr_stat = acc & pwrite & sel_stat;
   wire [31:0] rd_mux = sel_ctrl ? {16'h0, ctrl} :
      sel_stat ? {stat_cnt, `STAT_PAD, stat_flg} : 32'h0;
   wire [5:0] clr = wr_stat ? pwdata[`STAT_FLG] : 6'h0;
   wire [5:0] set = load ? fl : 6'h0;
   // set wins so a flag raised during a clear survives
   wire [5:0] next_flg = (stat_flg & ~clr) | set;
   assign pready = ce & setup_seen;
   assign pslverr = pready & psel & penable & ~hit;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ctrl <= `CTRL_RST;
         stat_flg <= 6'h0;
         stat_cnt <= 16'h0;
         setup_seen <= 1'b0;
         prdata <= 32'h0;
      end
      else if (ce)
      begin
         setup_seen <= psel & ~penable;
         if (psel & ~penable)
            prdata <= rd_mux;
         if (wr_ctrl)
            ctrl <= pwdata[15:0];
         stat_flg <= next_flg;
         if (load)
            stat_cnt <= stat_cnt + 16'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_ceil_zero: assert property (
      load && op == `OP_CEIL && a_mz |=> c_elem == 64'h0)
      else $error("ceiling of machine zero not zero");
   a_ceil_flags: assert property (
      load && op == `OP_CEIL |=> c_flags[4:0] == 5'h0)
      else $error("ceiling raised a flag other than 46");
   a_ceil_negexp: assert property (
      load && op == `OP_CEIL && !a_end && a_e[15]
      |=> c_elem[63:48] == 16'h0 && c_elem[47:0] == $past(ceil_c))
      else $error("ceiling negative exponent wrong");
   a_asig_ind: assert property (
      load && op == `OP_ASIG && a_ind
      |=> c_elem == `IND64 && c_flags[`F46])
      else $error("adjust significance indefinite wrong");
   a_aexp_endc: assert property (
      load && op == `OP_AEXP && ae_endc
      |=> c_elem == `IND64 && c_flags[`F46] && !c_flags[`F42])
      else $error("adjust exponent endcase wrong");
   a_aexp_bexp: assert property (
      load && op == `OP_AEXP && !ae_endc && !(d_pos && ae_big)
      |=> c_elem[63:48] == $past(b_e))
      else $error("adjust exponent did not take b exponent");
   a_xmit_copy: assert property (
      load && op == `OP_XMIT |=> c_elem == $past(a_elem))
      else $error("transmit changed the element");
   a_pack_form: assert property (
      load && op == `OP_PACK && !w32 |=>
      c_elem == {$past(a_elem[15:0]), $past(b_elem[47:0])})
      else $error("pack layout wrong");
   a_ext_low: assert property (
      load && op == `OP_EXT |=> c_elem[23:0] == 24'h0)
      else $error("extend low bits not cleared");
   a_out_hold: assert property (
      out_valid && !out_ready |=> out_valid && $stable(c_elem))
      else $error("result dropped under back pressure");

   c_ceil_neg: cover property (load && op == `OP_CEIL && a_e[15]);
   c_aexp_ovf: cover property (load && op == `OP_AEXP && fl[`F42]);
   c_rctr_carry: cover property (load && op == `OP_RCTR && rovf);
   c_stall: cover property (out_valid && !out_ready ##1 out_ready);
endmodule

// ---- operand_pipe.sv ----
// operand source and result sink standing in for the issue pipeline
`timescale 1ns/1ps
module operand_pipe
(
   input wire logic clk,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic [63:0] c_elem,
   input wire logic [5:0] c_flags,
   output logic in_valid,
   output logic [63:0] a_elem,
   output logic [63:0] b_elem,
   output logic out_ready
);
   initial
   begin
      in_valid = 1'b0;
      out_ready = 1'b0;
      a_elem = 64'h0;
      b_elem = 64'h0;
   end
   // one pair in, one result out; sink stalls for stall cycles
   task automatic xfer(input logic [63:0] a, input logic [63:0] b,
      input int stall, output logic [63:0] c, output logic [5:0] f,
      output logic hung);
      int n;
      @(posedge clk);
      in_valid <= 1'b1;
      a_elem <= a;
      b_elem <= b;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (in_ready !== 1'b1 && n < 40);
      hung = (n >= 40);
      in_valid <= 1'b0;
      // released operands flip so stale data never looks right
      a_elem <= ~a;
      b_elem <= ~b;
      repeat (stall) @(posedge clk);
      out_ready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (out_valid !== 1'b1 && n < 40);
      c = c_elem;
      f = c_flags;
      out_ready <= 1'b0;
      hung = hung | (n >= 40);
   endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the vector element float datapath
`timescale 1ns/1ps
`include "vec_ops_consts.svh"
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic in_valid;
   logic in_ready;
   logic out_valid;
   logic out_ready;
   logic a_reg_is_32;
   logic [63:0] a_elem;
   logic [63:0] b_elem;
   logic [63:0] c_elem;
   logic [5:0] c_flags;
   logic [31:0] rd;
   logic er;
   int n_errors = 0;
   int n_compared = 0;
   int n_el = 0;
   logic [63:0] la = 64'h00ff_0f0f_3333_5555;
   logic [63:0] lb = 64'h0f0f_00ff_5555_3333;
   always #25 clk = ~clk;
   vector_element_float_ops dut (.clk(clk), .rst_n(rst_n), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
      .a_elem(a_elem), .b_elem(b_elem), .out_valid(out_valid),
      .out_ready(out_ready), .c_elem(c_elem), .c_flags(c_flags),
      .a_reg_is_32(a_reg_is_32));
   operand_pipe pipe (.clk(clk), .in_ready(in_ready),
      .out_valid(out_valid), .c_elem(c_elem), .c_flags(c_flags),
      .in_valid(in_valid), .a_elem(a_elem), .b_elem(b_elem),
      .out_ready(out_ready));
   task automatic print_verdict();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40)
      begin
         n_errors++;
         $display("[FAIL] %0t pready got %h exp %h", $time, pready, 1'b1);
         print_verdict();
      end
   endtask
   // sub holds only the fields an operation uses, the rest zero
   task automatic run(input logic [7:0] op, input logic [7:0] sub,
      input logic [63:0] a, input logic [63:0] b, input logic [63:0] ec,
      input logic [5:0] ef);
      logic [63:0] c;
      logic [5:0] f;
      logic hung;
      apb(1'b1, `REG_CTRL, {16'h0000, sub, op});
      pipe.xfer(a, b, n_el % 3, c, f, hung);
      n_el++;
      if (hung)
      begin
         n_errors++;
         $display("[FAIL] %0t stream got %h exp %h", $time, hung, 1'b0);
         print_verdict();
      end
      chk(c, ec);
      chk({58'h0, f}, {58'h0, ef});
   endtask
   function automatic logic [63:0] lfn(input int k, input logic [63:0] a,
      input logic [63:0] b);
      case (k)
         0: return a ^ b;
         1: return a | b;
         2: return a & b;
         3: return ~(a & b);
         4: return ~(a | b);
         5: return ~a | b;
         6: return a & ~b;
         default: return ~(a ^ b);
      endcase
   endfunction
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `REG_CTRL, 32'h0);
      chk({32'h0, rd}, 64'h0);
      run(`OP_CEIL, 8'h00, 64'hffff_0000_0000_0003, 64'h0,
         64'h0000_0000_0000_0002, 6'h00);
      run(`OP_CEIL, 8'h00, `MZ64, 64'h0, 64'h0, 6'h00);
      run(`OP_SQRT, 8'h00, 64'h0000_ffff_ffff_fffc, 64'h0, `IND64,
         6'h10);
      // root of four is two: coefficient 2**24 at exponent -23
      run(`OP_SQRT, 8'h00, 64'h0000_0000_0000_0004, 64'h0,
         64'hffe9_0000_0100_0000, 6'h00);
      run(`OP_ASIG, 8'h00, 64'h0000_0000_0000_0001, 64'h2,
         64'hfffe_0000_0000_0004, 6'h00);
      run(`OP_ASIG, 8'h00, 64'h0000_2000_0000_0000, 64'h5,
         64'hffff_4000_0000_0000, 6'h00);
      run(`OP_ASIG, 8'h00, 64'h0, 64'h5, 64'hfffb_0000_0000_0000,
         6'h00);
      run(`OP_ASIG, 8'h00, 64'h0000_0000_0000_0008, 64'hffff_ffff_fffe,
         64'h0002_0000_0000_0002, 6'h00);
      run(`OP_ASIG, 8'h00, 64'h6fff_0000_0000_0001, 64'hffff_ffff_ffff,
         `IND64, 6'h02);
      run(`OP_ASIG, 8'h00, `IND64, 64'h1, `IND64, 6'h20);
      run(`OP_ASIG, 8'h00, `MZ64, 64'h1, `MZ64, 6'h04);
      run(`OP_AEXP, 8'h00, 64'h0003_0000_0000_0001, 64'h0001_0000_0000_0000,
         64'h0001_0000_0000_0004, 6'h00);
      run(`OP_AEXP, 8'h00, 64'h0001_0000_0000_0008, 64'h0003_0000_0000_0000,
         64'h0003_0000_0000_0002, 6'h00);
      run(`OP_AEXP, 8'h00, 64'h0005_0000_0000_0000, 64'h0007_0000_0000_0001,
         64'h0007_0000_0000_0000, 6'h00);
      run(`OP_AEXP, 8'h00, 64'h000a_4000_0000_0000, 64'h0, `IND64,
         6'h02);
      run(`OP_AEXP, 8'h00, `MZ64, 64'h0001_0000_0000_0001, `IND64,
         6'h20);
      run(`OP_CTR, 8'h00, 64'h0000_1234_5678_9abc, 64'h0,
         64'h0000_0000_1812_3456, 6'h00);
      run(`OP_RCTR, 8'h00, 64'h0000_1234_5680_0000, 64'h0,
         64'h0000_0000_1812_3457, 6'h00);
      run(`OP_RCTR, 8'h00, 64'h0000_7fff_ff80_0000, 64'h0,
         64'h0000_0000_1940_0000, 6'h00);
      run(`OP_XMIT, 8'h00, 64'h0123_4567_89ab_cdef, 64'h0,
         64'h0123_4567_89ab_cdef, 6'h00);
      run(`OP_ABS, 8'h00, 64'h0002_ffff_ffff_fffb, 64'h0,
         64'h0002_0000_0000_0005, 6'h00);
      run(`OP_EXPX, 8'h00, 64'hfffe_1234_0000_0000, 64'h0,
         64'h0000_ffff_ffff_fffe, 6'h00);
      run(`OP_PACK, 8'h00, 64'h5555_0000_0000_1234, 64'hffff_0000_abcd_0001,
         64'h1234_0000_abcd_0001, 6'h00);
      run(`OP_PACK, 8'h80, 64'h0000_0000_0000_0012, 64'h0000_0000_00ab_cdef,
         64'h0000_0000_12ab_cdef, 6'h00);
      run(`OP_EXT, 8'h10, 64'h1a12_3456, 64'h0,
         64'h0002_1234_5600_0000, 6'h00);
      chk({63'h0, a_reg_is_32}, 64'h1);
      run(`OP_EXT, 8'h00, 64'h7000_0000, 64'h0, `IND64, 6'h20);
      chk({63'h0, a_reg_is_32}, 64'h0);
      for (int k = 0; k < 8; k++)
      begin
         run(`OP_LOGIC, k[7:0], la, lb, lfn(k, la, lb), 6'h00);
      end
      // sticky flags: clear all, raise one, then clear it
      apb(1'b1, `REG_STAT, 32'h0000_003f);
      run(`OP_EXT, 8'h00, 64'h8000_0000, 64'h0, `MZ64, 6'h04);
      apb(1'b0, `REG_STAT, 32'h0);
      chk({32'h0, rd}, {32'h0, n_el[15:0], 16'h0004});
      apb(1'b1, `REG_STAT, 32'h0000_0004);
      apb(1'b0, `REG_STAT, 32'h0);
      chk({58'h0, rd[5:0]}, 64'h0);
      apb(1'b1, 12'h008, 32'hffff_ffff);
      chk({63'h0, er}, 64'h1);
      apb(1'b0, 12'h008, 32'h0);
      chk({31'h0, er, rd}, {31'h0, 1'b1, 32'h0});
      apb(1'b0, `REG_CTRL, 32'h0);
      chk({32'h0, rd}, {48'h0, 8'h00, `OP_EXT});
      // clock enable low must hold both handshakes off
      ce <= 1'b0;
      @(posedge clk);
      chk({62'h0, in_ready, pready}, 64'h0);
      ce <= 1'b1;
      print_verdict();
   end
endmodule
